// [rtl/xpc_call_return.sv]
// program counter extension with legacy and extended call and return
//
// What this block does
// RL1: all fetches, stack and data accesses drive a flat 20-bit address.
// RL2: legacy 16-bit instructions run unchanged with legacy results.
// RL3: the program counter is 20 bits wide and can run above 0x10000.
// RL4: extended call saves and extended return restores all 20 bits.
// RL5: a pc write keeps only its operand size; a word write zeroes bits 19:16.
// RL6: extended call pushes an extra word, moving the stack pointer two words.
// RL7: legacy call pushes one word; short return pops one, upper bits cleared.
`timescale 1ns/1ps
module xpc_call_return
  import xpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  output logic [ADDR_W-1:0] memAddr,
  output logic memRead,
  output logic memWrite,
  output logic [DATA_W-1:0] memWdata,
  input wire logic [DATA_W-1:0] memRdata,
  input wire logic memAck,
  output logic [ADDR_W-1:0] programCounter,
  output logic [ADDR_W-1:0] stackPointer,
  output logic instrDone
);

  function automatic logic [ADDR_W-1:0] stepUp(input logic [ADDR_W-1:0] a);
    stepUp = a + WORD_STEP;
  endfunction

  function automatic logic [ADDR_W-1:0] stepDown(
    input logic [ADDR_W-1:0] a
  );
    stepDown = a - WORD_STEP;
  endfunction

  // pc value carried by an operand word, widened by operand size
  function automatic logic [ADDR_W-1:0] operandTarget(
    input logic wide,
    input logic [HI_W-1:0] nib,
    input logic [DATA_W-1:0] word
  );
    operandTarget = wide ? {nib, word} : {{HI_W{1'b0}}, word}; // [RL5] [RL7]
  endfunction

  xpc_state_e state;
  logic [DATA_W-1:0] opcode;
  logic [DATA_W-1:0] popLow;
  logic [ADDR_W-1:0] jumpTarget;
  xpc_class_e opClass;
  logic wideOperand;
  logic [HI_W-1:0] hiNibble;
  logic busDone;
  logic busIdle;

  assign busDone = (memRead | memWrite) & memAck;
  assign busIdle = ~memRead & ~memWrite;

  xpc_op_decoder u_decoder (
    .opcode(opcode),
    .opClass(opClass),
    .wideOperand(wideOperand),
    .hiNibble(hiNibble)
  );

  // sequencing of fetch, operand, push and pop steps
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= ST_FETCH;
    end else begin
      unique case (state)
        ST_FETCH: if (busDone) state <= ST_DECODE;
        ST_DECODE: begin
          unique case (opClass)
            CLS_SHORT_CALL, CLS_EXTENDED_CALL, CLS_PC_MOVE:
              state <= ST_OPERAND;
            CLS_SHORT_RETURN, CLS_EXTENDED_RETURN: state <= ST_POP_LO;
            default: state <= ST_FETCH; // [RL2]
          endcase
        end
        ST_OPERAND: begin
          if (busDone) begin
            unique case (opClass)
              CLS_EXTENDED_CALL: state <= ST_PUSH_HI; // [RL6]
              CLS_SHORT_CALL: state <= ST_PUSH_LO; // [RL7]
              default: state <= ST_FETCH;
            endcase
          end
        end
        ST_PUSH_HI: if (busDone) state <= ST_PUSH_LO;
        ST_PUSH_LO: if (busDone) state <= ST_FETCH;
        ST_POP_LO: begin
          if (busDone) begin
            if (opClass == CLS_EXTENDED_RETURN) begin
              state <= ST_POP_HI; // [RL4]
            end else begin
              state <= ST_FETCH; // [RL7]
            end
          end
        end
        ST_POP_HI: if (busDone) state <= ST_FETCH;
      endcase
    end
  end

  // memory requests, held until acknowledged
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      memAddr <= '0;
      memRead <= 1'b0;
      memWrite <= 1'b0;
      memWdata <= '0;
    end else if (busDone) begin
      memRead <= 1'b0;
      memWrite <= 1'b0;
    end else if (busIdle) begin
      unique case (state)
        ST_FETCH, ST_OPERAND: begin
          memAddr <= programCounter; // [RL1] [RL3]
          memRead <= 1'b1;
        end
        ST_PUSH_HI: begin
          memAddr <= stepDown(stackPointer); // [RL1]
          memWdata <= {{(DATA_W-HI_W){1'b0}},
                       programCounter[ADDR_W-1:DATA_W]}; // [RL4] [RL6]
          memWrite <= 1'b1;
        end
        ST_PUSH_LO: begin
          memAddr <= stepDown(stackPointer);
          memWdata <= programCounter[DATA_W-1:0]; // [RL4] [RL7]
          memWrite <= 1'b1;
        end
        ST_POP_LO, ST_POP_HI: begin
          memAddr <= stackPointer; // [RL1]
          memRead <= 1'b1;
        end
        default: begin
          memRead <= 1'b0;
          memWrite <= 1'b0;
        end
      endcase
    end
  end

  // instruction and operand capture
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      opcode <= '0;
      jumpTarget <= '0;
      popLow <= '0;
    end else if (busDone) begin
      unique case (state)
        ST_FETCH: opcode <= memRdata;
        ST_OPERAND: begin
          jumpTarget <= operandTarget(wideOperand, hiNibble,
                                      memRdata); // [RL4] [RL5]
        end
        ST_POP_LO: popLow <= memRdata;
        default: popLow <= popLow;
      endcase
    end
  end

  // program counter: 20 bits, written by size of the operand
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      programCounter <= RESET_PC;
    end else if (busDone) begin
      unique case (state)
        ST_FETCH: programCounter <= stepUp(programCounter); // [RL3]
        ST_OPERAND: begin
          if (opClass == CLS_PC_MOVE) begin
            // move lands before the next fetch takes its address
            programCounter <= operandTarget(wideOperand, hiNibble,
                                            memRdata); // [RL5]
          end else begin
            programCounter <= stepUp(programCounter); // [RL3]
          end
        end
        ST_PUSH_LO: programCounter <= jumpTarget; // [RL4] [RL7]
        ST_POP_LO: begin
          if (opClass == CLS_SHORT_RETURN) begin
            programCounter <= {{HI_W{1'b0}}, memRdata}; // [RL7] [RL2]
          end
        end
        ST_POP_HI: begin
          programCounter <= {memRdata[HI_W-1:0], popLow}; // [RL4]
        end
        default: programCounter <= programCounter;
      endcase
    end
  end

  // pc move lands after its operand is taken
  logic moveLand;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      moveLand <= 1'b0;
    end else begin
      moveLand <= busDone && state == ST_OPERAND
                  && opClass == CLS_PC_MOVE;
    end
  end

  // stack pointer moves one word per push or pop
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stackPointer <= RESET_SP;
    end else if (busDone) begin
      unique case (state)
        ST_PUSH_HI, ST_PUSH_LO: begin
          stackPointer <= stepDown(stackPointer); // [RL6] [RL7]
        end
        ST_POP_LO, ST_POP_HI: begin
          stackPointer <= stepUp(stackPointer); // [RL4] [RL7]
        end
        default: stackPointer <= stackPointer;
      endcase
    end
  end

  // one-cycle pulse as each instruction retires
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      instrDone <= 1'b0;
    end else begin
      instrDone <= (state == ST_DECODE && opClass == CLS_OTHER)
                   || (busDone && (state == ST_PUSH_LO
                   || state == ST_POP_HI
                   || (state == ST_POP_LO
                       && opClass == CLS_SHORT_RETURN)))
                   || moveLand;
    end
  end

endmodule

// [pkg/xpc_pkg.sv]
// shared constants and types for the extended program counter block
package xpc_pkg;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int HI_W = ADDR_W - DATA_W;

  // program counter and stack pointer after reset
  localparam logic [ADDR_W-1:0] RESET_PC = 20'h0_0000;
  localparam logic [ADDR_W-1:0] RESET_SP = 20'h0_0A00;
  // bytes per 16-bit word on the address bus
  localparam logic [ADDR_W-1:0] WORD_STEP = 20'h0_0002;

  // opcode high byte of each handled instruction
  localparam logic [7:0] OPC_SHORT_CALL = 8'h12;
  localparam logic [7:0] OPC_EXTENDED_CALL = 8'h13;
  localparam logic [7:0] OPC_EXTENDED_RETURN = 8'h14;
  localparam logic [7:0] OPC_ADDR_MOVE = 8'h18;
  localparam logic [7:0] OPC_WORD_MOVE = 8'h40;
  localparam logic [7:0] OPC_SHORT_RETURN = 8'h41;

  // field positions inside an opcode word
  localparam int OPC_HI_LSB = 8;
  localparam int NIB_LSB = 0;

  typedef enum logic [5:0] {
    CLS_OTHER = 6'b000001,
    CLS_SHORT_CALL = 6'b000010,
    CLS_EXTENDED_CALL = 6'b000100,
    CLS_SHORT_RETURN = 6'b001000,
    CLS_EXTENDED_RETURN = 6'b010000,
    CLS_PC_MOVE = 6'b100000
  } xpc_class_e;

  typedef enum logic [6:0] {
    ST_FETCH = 7'b0000001,
    ST_DECODE = 7'b0000010,
    ST_OPERAND = 7'b0000100,
    ST_PUSH_HI = 7'b0001000,
    ST_PUSH_LO = 7'b0010000,
    ST_POP_LO = 7'b0100000,
    ST_POP_HI = 7'b1000000
  } xpc_state_e;

endpackage

// [rtl/xpc_op_decoder.sv]
// opcode classifier for the call, return and pc move instructions
`timescale 1ns/1ps
module xpc_op_decoder
  import xpc_pkg::*;
(
  input wire logic [DATA_W-1:0] opcode,
  output xpc_class_e opClass,
  output logic wideOperand,
  output logic [HI_W-1:0] hiNibble
);

  logic [7:0] opHi;

  assign opHi = opcode[OPC_HI_LSB +: 8];
  assign hiNibble = opcode[NIB_LSB +: HI_W];

  always_comb begin
    opClass = CLS_OTHER;
    wideOperand = 1'b0;
    unique case (opHi)
      OPC_SHORT_CALL: opClass = CLS_SHORT_CALL;
      OPC_EXTENDED_CALL: begin
        opClass = CLS_EXTENDED_CALL;
        wideOperand = 1'b1;
      end
      OPC_SHORT_RETURN: opClass = CLS_SHORT_RETURN;
      OPC_EXTENDED_RETURN: opClass = CLS_EXTENDED_RETURN;
      OPC_WORD_MOVE: opClass = CLS_PC_MOVE;
      OPC_ADDR_MOVE: begin
        opClass = CLS_PC_MOVE;
        wideOperand = 1'b1;
      end
      default: opClass = CLS_OTHER;
    endcase
  end

endmodule

// [testbench/xpc_call_return_chk.sv]
// port assertions for the call and return block
`timescale 1ns/1ps
module xpc_call_return_chk
  import xpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic memRead,
  input wire logic memWrite,
  input wire logic [DATA_W-1:0] memWdata,
  input wire logic memAck,
  input wire logic [ADDR_W-1:0] programCounter,
  input wire logic [ADDR_W-1:0] stackPointer,
  input wire logic instrDone
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_RD_HOLD: assert property (memRead && !memAck |=>
    memRead && $stable(memAddr)) else $error("read dropped early");
  AST_WR_HOLD: assert property (memWrite && !memAck |=> memWrite
    && $stable(memAddr) && $stable(memWdata)) else $error("write moved");
  AST_ACK_DROP: assert property ((memRead || memWrite) && memAck |=>
    !memRead && !memWrite) else $error("request kept after ack");
  AST_ONE_REQ: assert property (!(memRead && memWrite))
    else $error("read and write together");
  AST_RST_VAL: assert property ($rose(rst_n) |->
    programCounter == RESET_PC && stackPointer == RESET_SP)
    else $error("bad reset state");
  AST_SP_STEP: assert property ($changed(stackPointer) |->
    (stackPointer - $past(stackPointer)) inside
    {20'h00002, 20'h00004, 20'hFFFFE, 20'hFFFFC})
    else $error("stack pointer step wrong");
  AST_PUSH_AREA: assert property (memWrite |-> memAddr < stackPointer
    && memAddr >= stackPointer - 20'h00004) else $error("push outside");
  AST_DONE_FETCH: assert property (instrDone |-> ##[0:1]
    (memRead && memAddr == programCounter)) else $error("no fetch");
  cover property (instrDone && programCounter[19:16] != 4'h0);
  cover property (stackPointer == RESET_SP - 20'h00008);
  cover property (memAck && memWrite);
  cover property (instrDone && programCounter == 20'h14000);
endmodule
bind xpc_call_return xpc_call_return_chk chk (.ref_clk(ref_clk),
  .rst_n(rst_n), .memAddr(memAddr), .memRead(memRead),
  .memWrite(memWrite), .memWdata(memWdata), .memAck(memAck),
  .programCounter(programCounter), .stackPointer(stackPointer),
  .instrDone(instrDone));

// [testbench/xpc_mem_model.sv]
// program and data memory answering after a set wait
`timescale 1ns/1ps
module xpc_mem_model
  import xpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic memRead,
  input wire logic memWrite,
  input wire logic [DATA_W-1:0] memWdata,
  output logic [DATA_W-1:0] memRdata,
  output logic memAck,
  input wire logic [3:0] ackWait
);
  logic [DATA_W-1:0] mem [int];
  logic [3:0] cnt = 4'h0;
  initial memAck = 1'b0;
  initial memRdata = 16'h0000;
  // read data toggles except when answering a read
  always @(posedge ref_clk) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if ((memRead || memWrite) && !memAck) begin
      if (cnt < ackWait) cnt <= cnt + 4'h1;
      else begin
        cnt <= 4'h0;
        memAck <= 1'b1;
        if (memWrite) mem[memAddr] = memWdata;
        else memRdata <= mem.exists(memAddr) ? mem[memAddr] : 16'hDEAD;
      end
    end
  end
endmodule

// [testbench/xpc_call_return_test.sv]
// testbench for the call and return block
`timescale 1ns/1ps
module xpc_call_return_test
  import xpc_pkg::*;
;
  localparam logic [35:0] PROG [18] = '{36'h00000_1200, 36'h00002_0100,
    36'h00100_4100, 36'h00004_1301, 36'h00006_2000, 36'h12000_1300,
    36'h12002_0200, 36'h00200_1400, 36'h12004_4000, 36'h12006_0300,
    36'h00300_1400, 36'h00008_0000, 36'h0000A_1801, 36'h0000C_4000,
    36'h14000_0000, 36'h14002_1200, 36'h14004_0400, 36'h00400_4100};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] memAddr, programCounter, stackPointer;
  logic memRead, memWrite, memAck, instrDone;
  logic [DATA_W-1:0] memWdata, memRdata;
  logic [3:0] ackWait = 4'h0;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  always #50 ref_clk = ~ref_clk;
  xpc_call_return DUT (.ref_clk(ref_clk), .rst_n(rst_n), .memAddr(memAddr),
    .memRead(memRead), .memWrite(memWrite), .memWdata(memWdata),
    .memRdata(memRdata), .memAck(memAck), .instrDone(instrDone),
    .programCounter(programCounter), .stackPointer(stackPointer));
  xpc_mem_model mdl (.ref_clk(ref_clk), .memAddr(memAddr),
    .memRead(memRead), .memWrite(memWrite), .memWdata(memWdata),
    .memRdata(memRdata), .memAck(memAck), .ackWait(ackWait));
  task automatic check(input logic [ADDR_W-1:0] got,
    input logic [ADDR_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // waits until one instruction retires
  task automatic step();
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (instrDone !== 1'b1 && k < 300);
  endtask
  task automatic test_legacy();
    step();
    check(programCounter, 20'h00100);
    check(stackPointer, 20'h009FE);
    check(mdl.mem[20'h009FE], 20'h00004);
    step();
    check(programCounter, 20'h00004);
    check(stackPointer, 20'h00A00);
    $display("legacy call and return done");
  endtask
  task automatic test_extended();
    @(posedge ref_clk);
    ackWait <= 4'h3;
    step();
    check(programCounter, 20'h12000);
    check(stackPointer, 20'h009FC);
    check(mdl.mem[20'h009FE], 20'h00000);
    check(mdl.mem[20'h009FC], 20'h00008);
    step();
    check(mdl.mem[20'h009FA], 20'h00001);
    check(mdl.mem[20'h009F8], 20'h02004);
    check(programCounter, 20'h00200);
    check(stackPointer, 20'h009F8);
    step();
    check(programCounter, 20'h12004);
    check(stackPointer, 20'h009FC);
    $display("extended call and return done");
  endtask
  task automatic test_word_move();
    step();
    check(programCounter, 20'h00300);
    step();
    check(programCounter, 20'h00008);
    check(stackPointer, 20'h00A00);
    step();
    check(programCounter, 20'h0000A);
    $display("word move done");
  endtask
  task automatic test_addr_move();
    step();
    check(programCounter, 20'h14000);
    check(stackPointer, 20'h00A00);
    step();
    check(programCounter, 20'h14002);
    step();
    check(programCounter, 20'h00400);
    check(stackPointer, 20'h009FE);
    check(mdl.mem[20'h009FE], 20'h04006);
    step();
    check(programCounter, 20'h04006);
    check(stackPointer, 20'h00A00);
    $display("address move and high legacy call done");
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    foreach (PROG[i]) mdl.mem[PROG[i][35:16]] = PROG[i][15:0];
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_legacy();
    test_extended();
    test_word_move();
    test_addr_move();
    test_done();
  end
endmodule
